// ### design/nibble_alu.sv
// Nibble ALU with status flags and a small status word port.
// Assumes the sequencer drives requests on core_clk and acts on skip.
`timescale 1ns/100ps

// Operation
// - Arithmetic is add or subtract, register+memory or immediate+memory.
// - Binary works on the full nibble; decimal mode on one BCD digit.
// - Register sum adds register and memory, result to register.
// - Immediate sum adds immediate to memory, result to memory.
// - Sum with carry also adds carry; destination as for plain sum.
// - Register difference is register minus memory, to register.
// - Immediate difference is memory minus immediate, to memory.
// - Difference with borrow also subtracts carry; same destinations.
// - OR of operands; register form to register, immediate form to memory.
// - AND of operands; register form to register, immediate to memory.
// - XOR of operands; register form to register, immediate to memory.
// - Bits-set test clears suppress, skips if all masked bits are one.
// - Bits-clear test clears suppress, skips if all masked bits zero.
// - Equal test skips when memory minus immediate is zero.
// - Unequal test skips when memory minus immediate is nonzero.
// - Not-below test skips when the subtraction gives no borrow.
// - Below test skips when the subtraction gives a borrow.
// - Rotate shifts register right with carry, result to register.
// - Suppress blocks arithmetic writes; decimal flag selects BCD.
// - Zero cleared on nonzero; set on zero unless suppress holds it.
// - Carry follows arithmetic carry; logic ops and the equal, unequal and below tests keep flags.
// - Rotate puts old carry in bit 3, old bit 0 into carry.
module nibble_alu
    import nibble_alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input alu_req_t req,
    output alu_res_t res,
    output alu_flags_t flags,
    input wire logic [6:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////
    // State

    alu_state_t st_ff;
    alu_state_t nxt_st;
    logic [3:0] op_a;
    logic [3:0] op_b;
    logic cin;
    logic [4:0] sum5;
    logic [4:0] dif5;
    logic [4:0] cmp5;
    logic [4:0] adj5;
    logic [3:0] ar_data;
    logic ar_cy;
    logic is_ar;
    logic is_sub;

    assign res = st_ff.res;
    assign flags = st_ff.flags;
    assign reg_rdata = st_ff.rdata;

    ////////////////////////////////////////////////////////////////////
    // Datapath

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.res = '0;
        nxt_st.rdata = 4'h0;
        // Operand routing by form
        op_a = req.imm_form ? req.mem_val : req.reg_val;
        op_b = req.imm_form ? req.imm_val : req.mem_val;
        cin = st_ff.flags.carry_flag &
            ((req.op == sum_with_carry_op) |
            (req.op == difference_with_borrow_op));
        sum5 = {1'b0, op_a} + {1'b0, op_b} + {4'h0, cin};
        dif5 = {1'b0, op_a} - {1'b0, op_b} - {4'h0, cin};
        cmp5 = {1'b0, req.mem_val} - {1'b0, req.imm_val};
        adj5 = sum5 + BCD_ADJ5;
        is_sub = (req.op == difference_op) |
            (req.op == difference_with_borrow_op);
        is_ar = is_sub | (req.op == sum_op) |
            (req.op == sum_with_carry_op);
        // Binary or single-digit decimal result
        if (is_sub)
        begin
            ar_cy = dif5[4];
            ar_data = dif5[3:0];
            if (st_ff.flags.decimal && dif5[4])
            begin
                ar_data = dif5[3:0] - BCD_ADJ4;
            end
        end
        else
        begin
            ar_cy = sum5[4];
            ar_data = sum5[3:0];
            if (st_ff.flags.decimal && (sum5 > BCD_MAX))
            begin
                ar_cy = 1'b1;
                ar_data = adj5[3:0];
            end
        end
        if (req.valid)
        begin
            nxt_st.res.valid = 1'b1;
            unique case (req.op)
                sum_op, sum_with_carry_op,
                difference_op, difference_with_borrow_op:
                begin
                    nxt_st.res.data = ar_data;
                    nxt_st.res.reg_wr = !req.imm_form &
                        !st_ff.flags.compare_suppress_flag;
                    nxt_st.res.mem_wr = req.imm_form &
                        !st_ff.flags.compare_suppress_flag;
                    nxt_st.flags.carry_flag = ar_cy;
                    if (ar_data != 4'h0)
                    begin
                        nxt_st.flags.zero = 1'b0;
                    end
                    else if (!st_ff.flags.compare_suppress_flag)
                    begin
                        nxt_st.flags.zero = 1'b1;
                    end
                end
                or_op, and_op, xor_op:
                begin
                    if (req.op == or_op)
                    begin
                        nxt_st.res.data = op_a | op_b;
                    end
                    else if (req.op == and_op)
                    begin
                        nxt_st.res.data = op_a & op_b;
                    end
                    else
                    begin
                        nxt_st.res.data = op_a ^ op_b;
                    end
                    nxt_st.res.reg_wr = !req.imm_form;
                    nxt_st.res.mem_wr = req.imm_form;
                end
                skip_if_bits_set:
                begin
                    nxt_st.flags.compare_suppress_flag = 1'b0;
                    nxt_st.res.skip =
                        ((req.mem_val & req.imm_val) == req.imm_val);
                end
                skip_if_bits_clear:
                begin
                    nxt_st.flags.compare_suppress_flag = 1'b0;
                    nxt_st.res.skip =
                        ((req.mem_val & req.imm_val) == 4'h0);
                end
                skip_if_equal:
                begin
                    nxt_st.res.skip = (cmp5[3:0] == 4'h0);
                end
                skip_if_unequal:
                begin
                    nxt_st.res.skip = (cmp5[3:0] != 4'h0);
                end
                skip_if_not_below:
                begin
                    nxt_st.res.skip = !cmp5[4];
                end
                skip_if_below:
                begin
                    nxt_st.res.skip = cmp5[4];
                end
                rotate_right_through_carry:
                begin
                    nxt_st.res.data =
                        {st_ff.flags.carry_flag, req.reg_val[3:1]};
                    nxt_st.res.reg_wr = 1'b1;
                    nxt_st.flags.carry_flag = req.reg_val[0];
                end
                default:
                begin
                    nxt_st.res.valid = 1'b0;
                end
            endcase
        end
        // Status word access; a write overrides the flags in that cycle
        if (reg_rd)
        begin
            if (reg_addr == PSW_HI_ADDR)
            begin
                nxt_st.rdata[PSW_DEC_BIT] = st_ff.flags.decimal;
            end
            else if (reg_addr == PSW_LO_ADDR)
            begin
                nxt_st.rdata[PSW_CMP_BIT] = st_ff.flags.compare_suppress_flag;
                nxt_st.rdata[PSW_CY_BIT] = st_ff.flags.carry_flag;
                nxt_st.rdata[PSW_Z_BIT] = st_ff.flags.zero;
            end
        end
        if (reg_wr)
        begin
            if (reg_addr == PSW_HI_ADDR)
            begin
                nxt_st.flags.decimal = reg_wdata[PSW_DEC_BIT];
            end
            else if (reg_addr == PSW_LO_ADDR)
            begin
                nxt_st.flags.compare_suppress_flag = reg_wdata[PSW_CMP_BIT];
                nxt_st.flags.carry_flag = reg_wdata[PSW_CY_BIT];
                nxt_st.flags.zero = reg_wdata[PSW_Z_BIT];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff.res <= '0;
            st_ff.flags <= FLAGS_RST;
            st_ff.rdata <= 4'h0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic quiet;
    assign quiet = req.valid & !reg_wr;

    property p_sum_reg;
        quiet && req.op == sum_op && !req.imm_form &&
        !flags.compare_suppress_flag && !flags.decimal
        |=> res.valid && res.reg_wr && !res.mem_wr &&
        res.data == 4'($past(req.reg_val) + $past(req.mem_val));
    endproperty
    a_sum_reg: assert property (p_sum_reg)
        else $error("register sum wrong");

    property p_imm_sub;
        quiet && req.op == difference_op && req.imm_form &&
        !flags.compare_suppress_flag && !flags.decimal
        |=> res.mem_wr && !res.reg_wr &&
        res.data == 4'($past(req.mem_val) - $past(req.imm_val));
    endproperty
    a_imm_sub: assert property (p_imm_sub)
        else $error("immediate difference wrong");

    property p_suppress;
        req.valid && flags.compare_suppress_flag &&
        req.op inside {sum_op, sum_with_carry_op, difference_op,
        difference_with_borrow_op}
        |=> res.valid && !res.reg_wr && !res.mem_wr;
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("suppressed result written");

    property p_zero_hold;
        quiet && flags.compare_suppress_flag && !flags.zero &&
        req.op inside {sum_op, difference_op}
        |=> !flags.zero;
    endproperty
    a_zero_hold: assert property (p_zero_hold)
        else $error("zero set under suppress");

    property p_carry_add;
        quiet && req.op == sum_op && !flags.decimal
        |=> flags.carry_flag ==
        ((5'($past(op_a)) + 5'($past(op_b))) > 5'h0F);
    endproperty
    a_carry_add: assert property (p_carry_add)
        else $error("carry not from sum");

    property p_bits_set;
        quiet && req.op == skip_if_bits_set
        |=> !flags.compare_suppress_flag && !res.reg_wr && !res.mem_wr &&
        res.skip == (($past(req.mem_val) & $past(req.imm_val)) ==
        $past(req.imm_val));
    endproperty
    a_bits_set: assert property (p_bits_set)
        else $error("bit test wrong");

    property p_equal;
        req.valid && req.op == skip_if_equal
        |=> res.skip == ($past(req.mem_val) == $past(req.imm_val)) &&
        !res.mem_wr;
    endproperty
    a_equal: assert property (p_equal)
        else $error("equal skip wrong");

    property p_below;
        req.valid && req.op == skip_if_below
        |=> res.skip == ($past(req.mem_val) < $past(req.imm_val));
    endproperty
    a_below: assert property (p_below)
        else $error("below skip wrong");

    property p_rotate;
        quiet && req.op == rotate_right_through_carry
        |=> res.reg_wr && res.data[3] == $past(flags.carry_flag) &&
        flags.carry_flag == $past(req.reg_val[0]) &&
        res.data[2:0] == $past(req.reg_val[3:1]);
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("rotate wrong");

    property p_bcd;
        quiet && flags.decimal && req.op == sum_op &&
        op_a <= 4'h9 && op_b <= 4'h9
        |=> res.data <= 4'h9;
    endproperty
    a_bcd: assert property (p_bcd)
        else $error("decimal sum out of range");

    c_suppressed: cover property (req.valid &&
        flags.compare_suppress_flag ##1 res.valid);
    c_skip: cover property (res.skip);
    c_bcd_carry: cover property (flags.decimal && req.valid
        ##1 flags.carry_flag);

endmodule // nibble_alu

// ### design/nibble_alu_pkg.sv
// Package for the nibble ALU: operations, carriers, status addresses.
// Assumes one 200 MHz core clock shared with the sequencer.
package nibble_alu_pkg;

    localparam int NIB_W = 4;
    localparam logic [6:0] PSW_HI_ADDR = 7'h7E;
    localparam logic [6:0] PSW_LO_ADDR = 7'h7F;
    localparam int PSW_DEC_BIT = 0;
    localparam int PSW_CMP_BIT = 3;
    localparam int PSW_CY_BIT = 2;
    localparam int PSW_Z_BIT = 1;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [4:0] BCD_MAX = 5'h09;
    localparam logic [4:0] BCD_ADJ5 = 5'h06;
    localparam logic [3:0] BCD_ADJ4 = 4'h6;

    typedef enum logic [3:0] {
        sum_op = 4'b0000,
        sum_with_carry_op = 4'b0001,
        difference_op = 4'b0010,
        difference_with_borrow_op = 4'b0011,
        or_op = 4'b0100,
        and_op = 4'b0101,
        xor_op = 4'b0110,
        skip_if_bits_set = 4'b0111,
        skip_if_bits_clear = 4'b1000,
        skip_if_equal = 4'b1001,
        skip_if_unequal = 4'b1010,
        skip_if_not_below = 4'b1011,
        skip_if_below = 4'b1100,
        rotate_right_through_carry = 4'b1101,
        no_op = 4'b1110
    } alu_op_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic imm_form;
        logic [3:0] reg_val;
        logic [3:0] mem_val;
        logic [3:0] imm_val;
    } alu_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] data;
        logic reg_wr;
        logic mem_wr;
        logic skip;
    } alu_res_t;

    typedef struct packed {
        logic decimal;
        logic compare_suppress_flag;
        logic carry_flag;
        logic zero;
    } alu_flags_t;

    typedef struct packed {
        alu_res_t res;
        alu_flags_t flags;
        logic [3:0] rdata;
    } alu_state_t;

endpackage

// ### tb/seq_model.sv
// Sequencer model: advances its program counter on every ALU result.
// Assumes res is registered on core_clk and valid for one cycle.
`timescale 1ns/100ps
module seq_model
    import nibble_alu_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input alu_res_t res,
    output logic [15:0] pc_ff
);
    ////////////////////////////////////////////////////////////////////////
    // A skip passes over the following instruction
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pc_ff <= 16'h0000;
        else if (res.valid)
            pc_ff <= pc_ff + (res.skip ? 16'h0002 : 16'h0001);
    end
endmodule // seq_model

// ### tb/nibble_alu_instruction_datapath_tb.sv
// Testbench for the nibble ALU: directed and random operations, status port.
// Assumes one core clock and the operation codes of the package.
`timescale 1ns/100ps
module nibble_alu_instruction_datapath_tb;
    import nibble_alu_pkg::*;
    typedef struct packed {
        alu_res_t r;
        alu_flags_t f;
    } exp_t;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    alu_req_t req = '0;
    alu_res_t res;
    alu_flags_t flags;
    logic [6:0] reg_addr = 7'h00;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [3:0] reg_rdata;
    logic [15:0] pc_ff;
    int errors = 0;
    int samples_checked = 0;
    int nsteps = 0;
    integer seed = 32'hD77E5855;
    integer rnd;
    alu_flags_t mf = '0;
    exp_t q[$];
    exp_t me;
    ////////////////////////////////////////////////////////////////////////
    always #2.5 core_clk = ~core_clk;
    nibble_alu DUT (.core_clk(core_clk), .resetn(resetn), .req(req), .res(res),
        .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    seq_model partner (.core_clk(core_clk), .resetn(resetn), .res(res), .pc_ff(pc_ff));
    ////////////////////////////////////////////////////////////////////////
    task automatic check_value(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic exp_t model(input alu_op_t op, input logic fi,
        input logic [3:0] rv, input logic [3:0] mv, input logic [3:0] iv, input alu_flags_t f);
        exp_t e;
        logic [3:0] a;
        logic [3:0] b;
        logic [4:0] s;
        logic ci;
        logic ar;
        e = '0;
        e.f = f;
        e.r.valid = 1'h1;
        a = fi ? mv : rv;
        b = fi ? iv : mv;
        ci = (op == sum_with_carry_op || op == difference_with_borrow_op) && f.carry_flag;
        ar = 1'h0;
        s = {1'h0, mv} - {1'h0, iv};
        case (op)
            sum_op, sum_with_carry_op:
            begin
                ar = 1'h1;
                s = {1'h0, a} + {1'h0, b} + 5'(ci);
                if (f.decimal && s > 5'h09)
                    s = {1'h1, 4'(s[3:0] + 4'h6)};
            end
            difference_op, difference_with_borrow_op:
            begin
                ar = 1'h1;
                s = {1'h0, a} - {1'h0, b} - 5'(ci);
                if (f.decimal && s[4])
                    s[3:0] = s[3:0] - 4'h6;
            end
            or_op: e.r.data = a | b;
            and_op: e.r.data = a & b;
            xor_op: e.r.data = a ^ b;
            skip_if_bits_set: e.r.skip = (mv & iv) == iv;
            skip_if_bits_clear: e.r.skip = (mv & iv) == 4'h0;
            skip_if_equal: e.r.skip = s[3:0] == 4'h0;
            skip_if_unequal: e.r.skip = s[3:0] != 4'h0;
            skip_if_not_below: e.r.skip = !s[4];
            skip_if_below: e.r.skip = s[4];
            default:
            begin
                e.r.data = {f.carry_flag, rv[3:1]};
                e.r.reg_wr = 1'h1;
                e.f.carry_flag = rv[0];
            end
        endcase
        if (op == skip_if_bits_set || op == skip_if_bits_clear)
            e.f.compare_suppress_flag = 1'h0;
        if (op inside {or_op, and_op, xor_op})
            {e.r.reg_wr, e.r.mem_wr} = {!fi, fi};
        if (ar)
        begin
            e.r.data = s[3:0];
            e.r.reg_wr = !fi && !f.compare_suppress_flag;
            e.r.mem_wr = fi && !f.compare_suppress_flag;
            e.f.carry_flag = s[4];
            e.f.zero = (s[3:0] != 4'h0) ? 1'h0 : (f.compare_suppress_flag ? f.zero : 1'h1);
        end
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task automatic do_op(input alu_op_t op, input logic fi, input logic [3:0] rv,
        input logic [3:0] mv, input logic [3:0] iv);
        exp_t e;
        e = model(op, fi, rv, mv, iv, mf);
        q.push_back(e);
        mf = e.f;
        nsteps += e.r.skip ? 2 : 1;
        @(posedge core_clk);
        req <= {1'h1, op, fi, rv, mv, iv};
    endtask
    task automatic wr(input logic [6:0] a, input logic [3:0] d);
        @(posedge core_clk);
        req <= '0;
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        if (a == PSW_HI_ADDR)
            mf.decimal = d[0];
        if (a == PSW_LO_ADDR)
            {mf.compare_suppress_flag, mf.carry_flag, mf.zero} = d[3:1];
    endtask
    task automatic rd(input logic [6:0] a);
        logic [3:0] w;
        w = (a == PSW_HI_ADDR) ? {3'h0, mf.decimal} : (a == PSW_LO_ADDR) ?
            {mf.compare_suppress_flag, mf.carry_flag, mf.zero, 1'h0} : 4'h0;
        @(posedge core_clk);
        req <= '0;
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 check_value(16'(reg_rdata), 16'(w));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Monitor: every result pops the oldest expectation
    always @(negedge core_clk)
    begin
        if (res.valid === 1'h1)
        begin
            if (q.size() == 0)
                check_value(16'h0001, 16'h0000);
            else
            begin
                me = q.pop_front();
                check_value(16'({res.reg_wr, res.mem_wr, res.skip}),
                    16'({me.r.reg_wr, me.r.mem_wr, me.r.skip}));
                check_value(16'(flags), 16'(me.f));
                if (me.r.reg_wr || me.r.mem_wr)
                    check_value(16'(res.data), 16'(me.r.data));
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        #1 check_value(16'({res, flags}), 16'h0000);
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        rd(PSW_HI_ADDR);
        rd(PSW_LO_ADDR);
        wr(7'h7D, 4'hF);
        rd(7'h7D);
        rd(PSW_LO_ADDR);
        do_op(sum_op, 1'h0, 4'h3, 4'h4, 4'h0);
        for (int o = 0; o < 14; o++)
        begin
            do_op(alu_op_t'(4'(o)), 1'h0, 4'h5, 4'hC, 4'h9);
            do_op(alu_op_t'(4'(o)), 1'h1, 4'hA, 4'hC, 4'h4);
        end
        wr(PSW_HI_ADDR, 4'h1);
        do_op(sum_op, 1'h1, 4'h0, 4'h8, 4'h5);
        do_op(difference_with_borrow_op, 1'h0, 4'h3, 4'h5, 4'h0);
        wr(PSW_HI_ADDR, 4'h0);
        wr(PSW_LO_ADDR, 4'hA);
        do_op(difference_op, 1'h1, 4'h0, 4'h5, 4'h5);
        do_op(difference_op, 1'h1, 4'h0, 4'h6, 4'h5);
        do_op(difference_op, 1'h1, 4'h0, 4'h5, 4'h5);
        do_op(skip_if_bits_clear, 1'h1, 4'h0, 4'h5, 4'hA);
        rd(PSW_LO_ADDR);
        wr(PSW_LO_ADDR, 4'h4);
        do_op(rotate_right_through_carry, 1'h0, 4'h3, 4'h0, 4'h0);
        rd(PSW_LO_ADDR);
        // Mid-run reset clears the flags and the sequencer
        @(posedge core_clk);
        resetn <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1 check_value(16'({res, flags, reg_rdata}), 16'h0000);
        @(posedge core_clk);
        resetn <= 1'h1;
        mf = '0;
        nsteps = 0;
        for (int k = 0; k < 400; k++)
        begin
            rnd = $random(seed);
            if (k % 32 == 31)
            begin
                wr(PSW_LO_ADDR, rnd[15:12] & 4'hE);
                wr(PSW_HI_ADDR, {3'h0, rnd[16]});
                rd(PSW_LO_ADDR);
                rd(PSW_HI_ADDR);
            end
            if (mf.decimal)
                rnd[11:0] = {4'(rnd[11:8] % 10), 4'(rnd[7:4] % 10), 4'(rnd[3:0] % 10)};
            do_op(alu_op_t'(4'($unsigned(rnd[31:20]) % 14)), rnd[17],
                rnd[11:8], rnd[7:4], rnd[3:0]);
        end
        // A no_op request must give no result; the monitor flags any
        @(posedge core_clk);
        req <= {1'h1, no_op, 1'h0, 12'hFFF};
        for (int w = 0; w < 8 && q.size() != 0; w++)
            @(posedge core_clk);
        check_value(16'(q.size()), 16'h0000);
        repeat (2) @(posedge core_clk);
        check_value(pc_ff, 16'(nsteps));
        print_verdict();
    end
endmodule // nibble_alu_instruction_datapath_tb
